/* File: test/sbc_interrupt_wake_controller_tb_top.sv */
// bench for the interrupt aggregation block: source table, then timer and mode cases
// assumes apb transfers with no wait state and one-cycle event pulses
`timescale 1ns/10ps
module sbc_interrupt_wake_controller_tb_top import sbciwc_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int EW = $bits(sbciwc_evt_t);
  typedef struct {int p; int g; logic [7:0] v; logic u;} sbciwc_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, main_lvl, urg_lvl, main_oe, urg_oe, main_o, urg_o;
  logic chip_reset_out_n = 1'b1, in_low_power = 1'b0, clr = 1'b1;
  logic [EW-1:0] base = '0, ev = '0;
  logic [2:0] xcvr_active = '0, force_low, mode_field;
  sbciwc_modereq_t mode_req, seen;
  int n_fail = 0, n_compared = 0, n;
  time t0;
  // bit position in the event vector, pending group, expected pending, urgent
  sbciwc_row_t rows [24] = '{'{48, 0, 8'h04, 1}, '{47, 0, 8'h02, 0}, '{46, 0, 8'h02, 0},
    '{45, 0, 8'h02, 0}, '{44, 0, 8'h02, 0}, '{43, 0, 8'h02, 0}, '{50, 0, 8'h10, 0},
    '{49, 0, 8'h20, 1}, '{42, 1, 8'h01, 1}, '{41, 1, 8'h02, 0}, '{40, 1, 8'h04, 0},
    '{39, 1, 8'h08, 1}, '{38, 1, 8'h10, 1}, '{37, 1, 8'h20, 1}, '{51, 2, 8'h20, 0},
    '{36, 2, 8'h02, 0}, '{35, 2, 8'h10, 0}, '{34, 2, 8'h01, 0}, '{33, 2, 8'h04, 0},
    '{32, 2, 8'h08, 0}, '{24, 3, 8'h01, 0}, '{9, 4, 8'h02, 0}, '{20, 5, 8'h10, 0},
    '{7, 6, 8'h80, 0}};

  always #5 pclk = ~pclk;
  // one-cycle mode requests are kept until the bench clears them
  always @(posedge pclk) seen <= clr ? '0 : sbciwc_modereq_t'(seen | mode_req);

  sbciwc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(sbciwc_evt_t'(ev)), .xcvr_active(xcvr_active),
    .in_low_power(in_low_power), .chip_reset_out_n(chip_reset_out_n),
    .irq_main_n_i(main_lvl), .irq_main_n_o(main_o), .irq_main_n_oe(main_oe),
    .irq_urgent_n_i(urg_lvl), .irq_urgent_n_o(urg_o), .irq_urgent_n_oe(urg_oe),
    .bus_rx_pin_force_low(force_low), .mode_ctrl_field(mode_field), .mode_req(mode_req));
  sbciwc_host_pins HOST (.main_oe(main_oe), .main_o(main_o), .urg_oe(urg_oe),
    .urg_o(urg_o), .main_lvl(main_lvl), .urg_lvl(urg_lvl));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // request held until pready is sampled high; an idle cycle follows each transfer
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed here: only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] idx, input logic [31:0] x);
    apb(1'b0, idx, 8'h00);
    chk(r, x);
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  // pulse one event bit, then wait until pending and pins have settled
  task pulse(input int p);
    ev <= base | (EW'(1) << p);
    @(posedge pclk);
    ev <= base;
    repeat (2) @(posedge pclk);
  endtask
  task sleep_req;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    wr(IDX_MODE, 8'h01);
    repeat (2) @(posedge pclk);
  endtask
  task print_verdict;
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 29000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    clr <= 1'b0;
    @(posedge pclk);
    chk(main_lvl, 1'b1);
    rd(IDX_GLOBAL, 32'h0000_0000);
    rd(IDX_EN0, 32'h0000_0031);
    rd(8'h5f, 32'h0000_0000);
    chk(e, 1'b1);
    for (int g = 0; g < NREG; g++) wr(8'(IDX_EN0 + g), 8'hff);
    foreach (rows[i]) begin
      pulse(rows[i].p);
      chk(main_oe, 1'b1);
      chk(main_lvl, 1'b0);
      chk(urg_oe, rows[i].u);
      chk(urg_lvl, !rows[i].u);
      rd(8'(IDX_PEND0 + rows[i].g), 32'(rows[i].v));
      rd(IDX_GLOBAL, 32'h0000_0001 << rows[i].g);
      wr(8'(IDX_PEND0 + rows[i].g), 8'h00);
      rd(8'(IDX_PEND0 + rows[i].g), 32'(rows[i].v));
      wr(8'(IDX_PEND0 + rows[i].g), rows[i].v);
      @(posedge pclk);
      chk(main_oe, 1'b0);
      chk(urg_oe, 1'b0);
      repeat (1010) @(posedge pclk);
    end
    // new events during the delay: urgent at once, main only at expiry
    pulse(48);
    wr(IDX_PEND0, 8'h04);
    t0 = $time;
    pulse(50);
    pulse(48);
    chk(urg_oe, 1'b1);
    chk(main_oe, 1'b0);
    rd(IDX_PEND0, 32'h0000_0014);
    // pin status: timer running, urgent line low, main line high, something pending
    rd(IDX_PINS, 32'h0000_000b);
    n = 0;
    while (main_oe !== 1'b1 && n < 1500) begin
      @(posedge pclk);
      n++;
    end
    chk(($time - t0) / 10 inside {[995:1005]}, 1'b1);
    wr(IDX_PEND0, 8'h14);
    pulse(50);
    chip_reset_out_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chip_reset_out_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(main_oe, 1'b1);
    sleep_req;
    chk(seen.reset_mode, 1'b1);
    chk(mode_field, 3'h1);
    wr(IDX_PEND0, 8'h10);
    sleep_req;
    chk(seen.sleep_enter, 1'b1);
    chk(seen.reset_mode, 1'b0);
    for (int g = 0; g < NREG; g++) wr(8'(IDX_EN0 + g), 8'h00);
    sleep_req;
    chk(seen.sys_reset, 1'b1);
    // all enables cleared: only the always-enabled sources reach the pins
    repeat (1010) @(posedge pclk);
    pulse(48);
    chk(main_oe, 1'b0);
    chk(urg_oe, 1'b0);
    rd(IDX_PEND0, 32'h0000_0004);
    // a new event in the very cycle of the clear must keep the bit set
    fork
      wr(IDX_PEND0, 8'h04);
      begin
        @(posedge pclk);
        ev <= base | (EW'(1) << 48);
        @(posedge pclk);
        ev <= base;
      end
    join
    rd(IDX_PEND0, 32'h0000_0004);
    wr(IDX_PEND0, 8'h04);
    repeat (1010) @(posedge pclk);
    pulse(49);
    chk(main_oe, 1'b1);
    chk(urg_oe, 1'b1);
    chk(seen.overload, 1'b1);
    wr(IDX_PEND0, 8'h20);
    // second watchdog overflow while the first is pending
    base <= EW'(1) << 52;
    @(posedge pclk);
    pulse(53);
    rd(IDX_PEND0, 32'h0000_0001);
    pulse(53);
    chk(seen.chip_reset, 1'b1);
    wr(IDX_PEND0, 8'h01);
    base <= '0;
    pulse(34);
    chk(force_low, 3'b001);
    wr(8'(IDX_PEND0 + 2), 8'h01);
    chk(force_low, 3'b000);
    xcvr_active <= 3'b111;
    pulse(33);
    rd(8'(IDX_PEND0 + 2), 32'h0000_0000);
    in_low_power <= 1'b1;
    repeat (1010) @(posedge pclk);
    pulse(42);
    rd(8'(IDX_PEND0 + 1), 32'h0000_0000);
    pulse(50);
    chk(mode_req.wake_reset, 1'b1);
    in_low_power <= 1'b0;
    // reset in mid-run with a bit pending: everything must return to idle
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(main_oe, 1'b0);
    chk(mode_req.wake_reset, 1'b0);
    rd(IDX_GLOBAL, 32'h0000_0000);
    rd(IDX_EN0, 32'h0000_0031);
    print_verdict;
  end
endmodule

/* File: test/sbciwc_host_pins.sv */
// host side of the request lines: board pull-ups on both open-drain pins
// assumes oe high means the device pulls its line low
`timescale 1ns/10ps
module sbciwc_host_pins (
  input wire logic main_oe,
  input wire logic main_o,
  input wire logic urg_oe,
  input wire logic urg_o,
  output logic main_lvl,
  output logic urg_lvl
);
  // the pull-up sets the level whenever nobody pulls, so an idle line never floats
  assign main_lvl = main_oe ? main_o : 1'b1;
  assign urg_lvl = urg_oe ? urg_o : 1'b1;
endmodule

/* File: verilog/sbciwc_pkg.sv */
// interrupt and wake-up aggregation: shared constants, masks and carriers
// assumes an apb slave with 32-bit data, one register per aligned word
package sbciwc_pkg;

  // ----------------------------------------------------------------
  // clock and delay timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // delay timeout in microseconds, plain default
  localparam int unsigned IRQ_DELAY_TIMEOUT_US = 10;
  localparam int unsigned IRQ_DELAY_CYCLES = (IRQ_DELAY_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam int NREG = 7;
  localparam logic [7:0] IDX_GLOBAL = 8'h60;
  localparam logic [7:0] IDX_PEND0 = 8'h61; // system, supply, xcvr, b0w, b0f, b1w, b1f
  localparam logic [7:0] IDX_EN0 = 8'h69; // enables, same order as pending
  localparam logic [7:0] IDX_MODE = 8'h70;
  localparam logic [7:0] IDX_PINS = 8'h71;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int G_SYS = 0;
  localparam int G_SUP = 1;
  localparam int G_XCVR = 2;
  localparam int G_B0W = 3;
  localparam int G_B0F = 4;
  localparam int G_B1W = 5;
  localparam int G_B1F = 6;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h1;

  // per register masks: implemented, always enabled, urgent, regular wake
  localparam logic [7:0] VLD_MASK [0:NREG-1] = '{8'h37, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] AON_MASK [0:NREG-1] = '{8'h31, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] URG_MASK [0:NREG-1] = '{8'h24, 8'h39, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] REG_MASK [0:NREG-1] = '{8'h00, 8'h00, 8'h0d, 8'hff, 8'h00, 8'hff, 8'h00};

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // one-cycle event pulses from the sources, levels where noted
  typedef struct packed {
    logic wdog_overflow;
    logic wdog_timeout_mode; // level
    logic pn_frame_err;
    logic power_on;
    logic batt_overvolt;
    logic overtemp_warn;
    logic illegal_wdog_mode;
    logic illegal_wdog_period;
    logic illegal_mode;
    logic bad_frame_len;
    logic locked_write;
    logic main_reg_under;
    logic aux_supply_under;
    logic aux_supply_over;
    logic batt_mon_under;
    logic batt_mon_over;
    logic converter_state_flag; // level
    logic can_fail;
    logic can_silence;
    logic can_wake;
    logic lin_a_wake;
    logic lin_b_wake;
    logic [7:0] hv_io_pin_rise_wake;
    logic [7:0] hv_io_pin_fall_wake;
    logic [7:0] hv_io_pin_open_load;
    logic [7:0] hv_io_pin_short;
  } sbciwc_evt_t;

  // one-cycle requests to the mode controller, wake is a level
  typedef struct packed {
    logic sys_reset;
    logic reset_mode;
    logic sleep_enter;
    logic wake_reset;
    logic overload;
    logic chip_reset;
  } sbciwc_modereq_t;

endpackage

/* File: verilog/sbciwc_top.sv */
// interrupt and wake-up aggregation: pending bits, request pins, delay timer
// assumes synchronous event pulses and an apb master on pclk
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps

module sbciwc_top
  import sbciwc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sbciwc_evt_t evt,
  input wire logic [2:0] xcvr_active,
  input wire logic in_low_power,
  input wire logic chip_reset_out_n,
  input wire logic irq_main_n_i,
  output logic irq_main_n_o,
  output logic irq_main_n_oe,
  input wire logic irq_urgent_n_i,
  output logic irq_urgent_n_o,
  output logic irq_urgent_n_oe,
  output logic [2:0] bus_rx_pin_force_low,
  output logic [2:0] mode_ctrl_field,
  output sbciwc_modereq_t mode_req
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // true for every index that answers without error
  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx >= IDX_GLOBAL) && (idx <= IDX_PINS);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] pend [0:NREG-1]; // sticky pending bits
  logic [7:0] en [0:NREG-1]; // software enables
  logic [7:0] en_eff [0:NREG-1]; // enables with always-on forced
  logic [7:0] ev_set [0:NREG-1]; // set pulses this cycle
  logic [7:0] clr [0:NREG-1]; // write-one clear this cycle
  logic [7:0] idx; // word index of the bus address
  logic addr_ok; // aligned and mapped
  logic apb_setup; // setup phase
  logic apb_wr; // write takes effect now
  logic [7:0] rd_val; // read mux
  logic [7:0] gsum; // group summary
  logic req_main; // enabled pending, main pin
  logic req_urg; // enabled pending, urgent pin
  logic any_pend; // any pending bit at all
  logic any_regular_en; // any regular wake enabled
  logic tmr_start; // a clear hit a set bit
  logic tmr_run; // delay timer running
  logic [15:0] tmr_cnt; // cycles left
  logic conv_prev; // converter flag last cycle
  logic conv_seen; // conv_prev holds a real sample
  logic sleep_wr; // sleep code written
  logic wdog_ovf; // overflow counted in timeout mode

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && idx_mapped(idx);
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite && addr_ok;
  assign sleep_wr = apb_wr && (idx == IDX_MODE) && (pwdata[2:0] == MODE_SLEEP);
  assign wdog_ovf = evt.wdog_overflow && evt.wdog_timeout_mode;

  // ----------------------------------------------------------------
  // event capture
  // ----------------------------------------------------------------
  // map source pulses onto bit positions; unused positions stay zero
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      ev_set[i] = 8'h00;
    end
    ev_set[G_SYS][5] = evt.batt_overvolt;
    ev_set[G_SYS][4] = evt.power_on;
    ev_set[G_SYS][2] = evt.overtemp_warn;
    ev_set[G_SYS][1] = evt.illegal_wdog_mode | evt.illegal_wdog_period | evt.illegal_mode |
                       evt.bad_frame_len | evt.locked_write;
    ev_set[G_SYS][0] = wdog_ovf;
    ev_set[G_SUP][5] = conv_seen && (evt.converter_state_flag != conv_prev);
    ev_set[G_SUP][4] = evt.batt_mon_over;
    ev_set[G_SUP][3] = evt.batt_mon_under;
    ev_set[G_SUP][2] = evt.aux_supply_over;
    ev_set[G_SUP][1] = evt.aux_supply_under;
    ev_set[G_SUP][0] = evt.main_reg_under && !in_low_power;
    ev_set[G_XCVR][5] = evt.pn_frame_err;
    ev_set[G_XCVR][4] = evt.can_silence;
    // bus wakes only count while the transceiver is not active
    ev_set[G_XCVR][3] = evt.lin_b_wake && !xcvr_active[2];
    ev_set[G_XCVR][2] = evt.lin_a_wake && !xcvr_active[1];
    ev_set[G_XCVR][1] = evt.can_fail;
    ev_set[G_XCVR][0] = evt.can_wake && !xcvr_active[0];
    ev_set[G_B0W] = {evt.hv_io_pin_fall_wake[3:0], evt.hv_io_pin_rise_wake[3:0]};
    ev_set[G_B0F] = {evt.hv_io_pin_short[3:0], evt.hv_io_pin_open_load[3:0]};
    ev_set[G_B1W] = {evt.hv_io_pin_fall_wake[7:4], evt.hv_io_pin_rise_wake[7:4]};
    ev_set[G_B1F] = {evt.hv_io_pin_short[7:4], evt.hv_io_pin_open_load[7:4]};
  end

  // converter flag history; the first sample after reset is not a change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_prev <= 1'b0;
      conv_seen <= 1'b0;
    end else begin
      conv_prev <= evt.converter_state_flag;
      conv_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pending and enable registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gen_reg
      // clear mask from the write data, only on implemented bits
      assign clr[g] = (apb_wr && (idx == IDX_PEND0 + 8'(g))) ? (pwdata[7:0] & VLD_MASK[g]) :
                      8'h00;
      // always-on sources ignore the enable bit
      assign en_eff[g] = en[g] | AON_MASK[g];

      // sticky bit: a set pulse wins over a clear in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend[g] <= 8'h00;
        end else begin
          pend[g] <= (ev_set[g] & VLD_MASK[g]) | (pend[g] & ~clr[g]);
        end
      end

      // enables; always-on positions cannot be stored
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          en[g] <= EN_RST;
        end else if (apb_wr && (idx == IDX_EN0 + 8'(g))) begin
          en[g] <= pwdata[7:0] & VLD_MASK[g] & ~AON_MASK[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // request forming
  // ----------------------------------------------------------------
  // summary, pin requests and sleep conditions from all registers
  always_comb begin
    req_main = 1'b0;
    req_urg = 1'b0;
    any_pend = 1'b0;
    any_regular_en = 1'b0;
    tmr_start = 1'b0;
    gsum = 8'h00; // bit 7 stays reserved
    for (int i = 0; i < NREG; i++) begin
      gsum[i] = |pend[i];
      req_main = req_main | (|(pend[i] & en_eff[i]));
      req_urg = req_urg | (|(pend[i] & en_eff[i] & URG_MASK[i]));
      any_pend = any_pend | (|pend[i]);
      any_regular_en = any_regular_en | (|(en[i] & REG_MASK[i]));
      tmr_start = tmr_start | (|(clr[i] & pend[i]));
    end
  end

  // ----------------------------------------------------------------
  // interrupt delay timer
  // ----------------------------------------------------------------
  // reload on every effective clear; chip reset low kills it at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_run <= 1'b0;
      tmr_cnt <= 16'h0000;
    end else if (!chip_reset_out_n) begin
      tmr_run <= 1'b0;
      tmr_cnt <= 16'h0000;
    end else if (tmr_start) begin
      tmr_run <= 1'b1;
      tmr_cnt <= 16'(IRQ_DELAY_CYCLES);
    end else if (tmr_run) begin
      tmr_cnt <= tmr_cnt - 16'h0001;
      tmr_run <= (tmr_cnt != 16'h0001);
    end
  end

  // ----------------------------------------------------------------
  // request pins
  // ----------------------------------------------------------------
  // pins only ever sink; the board pull-up supplies the high level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_main_n_o <= 1'b0;
      irq_urgent_n_o <= 1'b0;
      irq_main_n_oe <= 1'b0;
      irq_urgent_n_oe <= 1'b0;
    end else begin
      irq_main_n_o <= 1'b0;
      irq_urgent_n_o <= 1'b0;
      irq_main_n_oe <= req_main && !tmr_run && !tmr_start;
      irq_urgent_n_oe <= req_urg;
    end
  end

  // receive pins follow the bus wake pending bits
  assign bus_rx_pin_force_low = {pend[G_XCVR][3], pend[G_XCVR][2], pend[G_XCVR][0]};

  // ----------------------------------------------------------------
  // mode field and mode requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ctrl_field <= MODE_RST;
    end else if (apb_wr && (idx == IDX_MODE)) begin
      mode_ctrl_field <= pwdata[2:0];
    end
  end

  // sleep checks: no regular enable first, then anything pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_req <= '0;
    end else begin
      mode_req.sys_reset <= sleep_wr && !any_regular_en;
      mode_req.reset_mode <= sleep_wr && any_regular_en && any_pend;
      mode_req.sleep_enter <= sleep_wr && any_regular_en && !any_pend;
      mode_req.wake_reset <= in_low_power && req_main;
      mode_req.overload <= evt.batt_overvolt;
      mode_req.chip_reset <= wdog_ovf && pend[G_SYS][0];
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // read mux; the pin status word shows the real wire levels
  always_comb begin
    rd_val = 8'h00;
    if (idx == IDX_GLOBAL) begin
      rd_val = gsum;
    end else if (idx == IDX_MODE) begin
      rd_val = {5'h00, mode_ctrl_field};
    end else if (idx == IDX_PINS) begin
      rd_val = {4'h0, tmr_run, irq_urgent_n_i, irq_main_n_i, any_pend};
    end
    for (int i = 0; i < NREG; i++) begin
      if (idx == IDX_PEND0 + 8'(i)) begin
        rd_val = pend[i];
      end
      if (idx == IDX_EN0 + 8'(i)) begin
        rd_val = en_eff[i];
      end
    end
  end

  // no wait state: data is latched in setup so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      if (apb_setup) begin
        prdata <= addr_ok ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_MAIN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (req_main && !tmr_run && !tmr_start) |=> irq_main_n_oe)
    else $error("main pin not pulled for enabled pending");

  AST_URGENT_FAST: assert property (@(posedge pclk) disable iff (!presetn)
    (req_urg && tmr_run) |=> irq_urgent_n_oe)
    else $error("urgent pin held off by delay timer");

  AST_NEVER_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (!irq_main_n_o && !irq_urgent_n_o))
    else $error("request pin driven high");

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_set[G_SYS][2] && clr[G_SYS][2]) |=> pend[G_SYS][2])
    else $error("set lost against clear");

  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (clr[G_SUP] != 8'h00 && ev_set[G_SUP] == 8'h00) |=>
    ((pend[G_SUP] & $past(clr[G_SUP])) == 8'h00) &&
    (pend[G_SUP] == ($past(pend[G_SUP]) & ~$past(clr[G_SUP]))))
    else $error("write one clear wrong");

  AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    !any_pend |=> (!irq_main_n_oe && !irq_urgent_n_oe))
    else $error("pins held with nothing pending");

  AST_DELAY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (tmr_start && chip_reset_out_n) |=> (!irq_main_n_oe && tmr_run))
    else $error("main pin not released on clear");

  AST_EXPIRE: assert property (@(posedge pclk) disable iff (!presetn)
    (tmr_run && tmr_cnt == 16'h0001 && !tmr_start && chip_reset_out_n && req_main)
    |=> !tmr_run ##1 irq_main_n_oe)
    else $error("main pin not driven after expiry");

  AST_TIMER_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_reset_out_n |=> !tmr_run)
    else $error("timer ran during chip reset");

  AST_SLEEP_NOREG: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_wr && !any_regular_en) |=> (mode_req.sys_reset && !mode_req.sleep_enter))
    else $error("sleep entered with no regular enable");

  AST_SLEEP_PEND: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_wr && any_regular_en && any_pend) |=> (mode_req.reset_mode && !mode_req.sleep_enter))
    else $error("sleep entered while pending");

  AST_RX_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    (evt.can_wake && !xcvr_active[0]) |=> bus_rx_pin_force_low[0])
    else $error("receive pin not forced on bus wake");

  AST_WDOG_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    (wdog_ovf && pend[G_SYS][0]) |=> (mode_req.chip_reset && pend[G_SYS][0]))
    else $error("second overflow did not reset");

  AST_OVV: assert property (@(posedge pclk) disable iff (!presetn)
    evt.batt_overvolt |=> (mode_req.overload && pend[G_SYS][5]) ##1 irq_urgent_n_oe)
    else $error("overvoltage not handled");

  AST_NO_SLEEP_UNDER: assert property (@(posedge pclk) disable iff (!presetn)
    (in_low_power && !pend[G_SUP][0]) |=> !pend[G_SUP][0])
    else $error("main undervoltage raised in sleep");

endmodule
